// file: hw/pim_mapper.sv
// process image mapper: walks the terminal rail, builds the input image and sends out the output image
// assumes terminal chain logic answers combinationally for the slot shown
`timescale 1ns/1ps
module pim_mapper
  import pim_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [5:0]  plc_addr,
  input  wire logic        plc_wr,
  input  wire logic [7:0]  plc_wdata,
  output logic      [7:0]  plc_rdata,
  output logic      [4:0]  tb_slot,
  input  wire logic [2:0]  tb_kind,
  input  wire logic [1:0]  tb_ctl_en,
  input  wire logic        tb_res12,
  output logic      [2:0]  tb_byte_sel,
  input  wire logic [7:0]  tb_rd_data,
  output logic      [7:0]  tb_wr_data,
  output logic             tb_byte_wr,
  input  wire logic [1:0]  tb_bits_in,
  output logic      [1:0]  tb_bits_out,
  output logic             tb_bits_wr,
  output logic             reg_acc,
  output logic             reg_acc_wr,
  output logic      [5:0]  reg_acc_addr,
  output logic             img_done,
  output logic      [6:0]  in_len,
  output logic      [6:0]  out_len
);

  pim_state_s r_reg;
  pim_state_s r_next;

  pim_ram_if in_if ();
  pim_ram_if out_if ();

  // ------------------------------------------------------------
  // image memories
  // ------------------------------------------------------------
  pim_ram u_in_img (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .port (in_if.mem)
  );

  pim_ram u_out_img (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .port (out_if.mem)
  );

  logic       walk_we;
  logic [5:0] walk_waddr;
  logic [7:0] walk_wdata;
  logic [5:0] walk_raddr;
  logic       is_ana;
  logic       is_byte;
  logic       ch_ctl;
  logic [1:0] k;
  logic [7:0] ctl;
  logic [7:0] acc_v;
  logic       adv;
  logic [2:0] last_idx;

  assign in_if.we     = walk_we;
  assign in_if.waddr  = walk_waddr;
  assign in_if.wdata  = walk_wdata;
  assign in_if.raddr  = plc_addr;
  assign out_if.we    = plc_wr;
  assign out_if.waddr = plc_addr;
  assign out_if.wdata = plc_wdata;
  assign out_if.raddr = walk_raddr;

  assign is_ana   = (tb_kind == PIM_K_AIN) || (tb_kind == PIM_K_AOUT);
  assign is_byte  = is_ana || (tb_kind == PIM_K_SER);
  assign k        = r_reg.bidx[1:0];
  assign ch_ctl   = tb_ctl_en[r_reg.bidx[2]];
  assign ctl      = out_if.rdata;
  assign last_idx = is_ana ? PIM_ANA_LAST : PIM_SER_LAST;

  // ------------------------------------------------------------
  // rail walker
  // ------------------------------------------------------------
  always_comb begin
    r_next       = r_reg;
    r_next.bwr   = 1'b0;
    r_next.bitwr = 1'b0;
    r_next.acc   = 1'b0;
    r_next.done  = 1'b0;
    walk_we      = 1'b0;
    walk_waddr   = r_reg.bptr;
    walk_wdata   = PIM_ZERO_BYTE;
    walk_raddr   = r_reg.bptr;
    acc_v        = PIM_ZERO_BYTE;
    adv          = 1'b0;
    unique case (r_reg.st)
      PIM_ST_BYTE_REQ: begin
        if (is_byte) begin
          r_next.st = PIM_ST_BYTE_XFER;
        end else begin
          adv = 1'b1;
        end
      end
      PIM_ST_BYTE_XFER: begin
        walk_we      = 1'b1;
        r_next.bwr   = 1'b1;
        walk_wdata   = tb_rd_data;
        r_next.wdata = ctl;
        if (is_ana) begin
          unique case (k)
            PIM_K_CTL: begin
              if (!ch_ctl) begin
                walk_wdata   = PIM_ZERO_BYTE;
                r_next.wdata = PIM_ZERO_BYTE;
              end else if (ctl[PIM_MODE_BIT]) begin
                walk_wdata = ctl;
              end else begin
                walk_wdata = {1'b0, tb_rd_data[PIM_DIR_BIT:0]};
              end
            end
            PIM_K_EMPTY: begin
              walk_wdata   = PIM_ZERO_BYTE;
              r_next.wdata = PIM_ZERO_BYTE;
            end
            PIM_K_DLO: begin
              walk_wdata = tb_res12 ? (tb_rd_data & PIM_RES12_MSK) : tb_rd_data;
            end
            default: begin
              walk_wdata = tb_rd_data;
            end
          endcase
          if (k == PIM_K_CTL && ch_ctl && ctl[PIM_MODE_BIT]) begin
            r_next.acc     = 1'b1;
            r_next.accwr   = ctl[PIM_DIR_BIT];
            r_next.accaddr = ctl[PIM_ADDR_MSB:0];
          end
        end
        r_next.bptr = r_reg.bptr + 6'h01;
        r_next.st   = PIM_ST_BYTE_REQ;
        if (r_reg.bidx == last_idx) begin
          r_next.bidx = 3'h0;
          adv         = 1'b1;
        end else begin
          r_next.bidx = r_reg.bidx + 3'h1;
        end
      end
      PIM_ST_BIT_REQ: begin
        if (tb_kind == PIM_K_DIN) begin
          acc_v = ((r_reg.ibit[2:0] == 3'h0) ? PIM_ZERO_BYTE : r_reg.iacc)
                  | ({6'h00, tb_bits_in} << r_reg.ibit[2:0]);
          r_next.iacc = acc_v;
          walk_we     = 1'b1;
          walk_waddr  = r_reg.bit_base + {1'b0, r_reg.ibit[7:3]};
          walk_wdata  = acc_v;
          r_next.ibit = r_reg.ibit + PIM_DIG_STEP;
          adv         = 1'b1;
        end else if (tb_kind == PIM_K_DOUT) begin
          walk_raddr = r_reg.bit_base + {1'b0, r_reg.obit[7:3]};
          r_next.st  = PIM_ST_BIT_XFER;
        end else begin
          adv = 1'b1;
        end
      end
      PIM_ST_BIT_XFER: begin
        walk_raddr   = r_reg.bit_base + {1'b0, r_reg.obit[7:3]};
        acc_v        = out_if.rdata >> r_reg.obit[2:0];
        r_next.bout  = acc_v[1:0];
        r_next.bitwr = 1'b1;
        r_next.obit  = r_reg.obit + PIM_DIG_STEP;
        r_next.st    = PIM_ST_BIT_REQ;
        adv          = 1'b1;
      end
      PIM_ST_DONE: begin
        r_next.done    = 1'b1;
        r_next.in_len  = {1'b0, r_reg.bit_base}
                         + 7'((9'(r_reg.ibit) + PIM_BYTE_RND) >> 3);
        r_next.out_len = {1'b0, r_reg.bit_base}
                         + 7'((9'(r_reg.obit) + PIM_BYTE_RND) >> 3);
        r_next.st      = PIM_ST_BYTE_REQ;
        r_next.slot    = 5'h00;
        r_next.bptr    = 6'h00;
        r_next.bidx    = 3'h0;
      end
      default: begin
        r_next.st = PIM_ST_DONE;
      end
    endcase
    if (adv) begin
      if (r_reg.slot != PIM_LAST_SLOT) begin
        r_next.slot = r_reg.slot + 5'h01;
      end else if (r_reg.st == PIM_ST_BYTE_REQ || r_reg.st == PIM_ST_BYTE_XFER) begin
        r_next.st       = PIM_ST_BIT_REQ;
        r_next.slot     = 5'h00;
        r_next.bit_base = r_next.bptr;
        r_next.ibit     = 8'h00;
        r_next.obit     = 8'h00;
        r_next.iacc     = PIM_ZERO_BYTE;
      end else begin
        r_next.st = PIM_ST_DONE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign plc_rdata    = in_if.rdata;
  assign tb_slot      = r_reg.slot;
  assign tb_byte_sel  = r_reg.bidx;
  assign tb_wr_data   = r_reg.wdata;
  assign tb_byte_wr   = r_reg.bwr;
  assign tb_bits_out  = r_reg.bout;
  assign tb_bits_wr   = r_reg.bitwr;
  assign reg_acc      = r_reg.acc;
  assign reg_acc_wr   = r_reg.accwr;
  assign reg_acc_addr = r_reg.accaddr;
  assign img_done     = r_reg.done;
  assign in_len       = r_reg.in_len;
  assign out_len      = r_reg.out_len;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  logic ana_x;
  assign ana_x = (r_reg.st == PIM_ST_BYTE_XFER) && is_ana;

  a_byte_step: assert property (ce && r_reg.st == PIM_ST_BYTE_XFER
    |=> r_reg.bptr == $past(r_reg.bptr) + 6'h01)
    else $error("byte pointer did not advance");
  a_empty_zero: assert property (ana_x && k == PIM_K_EMPTY
    |-> walk_we && walk_wdata == 8'h00 && r_next.wdata == 8'h00)
    else $error("empty analog byte not zero");
  a_bits_after: assert property (r_reg.st == PIM_ST_BIT_REQ && walk_we
    |-> walk_waddr >= r_reg.bit_base)
    else $error("bit data below byte area");
  a_pad_zero: assert property (r_reg.st == PIM_ST_BIT_REQ && walk_we
    |-> (walk_wdata >> ({1'b0, r_reg.ibit[2:0]} + 4'h2)) == 8'h00)
    else $error("unused bits not zero");
  a_passive_skip: assert property (ce && r_reg.st == PIM_ST_BYTE_REQ
    && !is_byte |=> $stable(r_reg.bptr))
    else $error("passive terminal moved address");
  a_res12_mask: assert property (ana_x && k == PIM_K_DLO && tb_res12
    |-> walk_wdata[3:0] == 4'h0)
    else $error("low nibble not masked");
  a_ctl_off: assert property (ana_x && k == PIM_K_CTL && !ch_ctl
    |-> walk_wdata == 8'h00 && !r_next.acc)
    else $error("control byte present while disabled");
  a_reg_req: assert property (ce && ana_x && k == PIM_K_CTL && ch_ctl
    && ctl[7] |=> reg_acc && reg_acc_wr == $past(ctl[6])
    && reg_acc_addr == $past(ctl[5:0]))
    else $error("register access not raised");
  a_no_req: assert property (ce && !(ana_x && k == PIM_K_CTL && ch_ctl
    && ctl[7]) |=> !reg_acc)
    else $error("spurious register access");
  a_status_echo: assert property (ana_x && k == PIM_K_CTL && ch_ctl
    && ctl[7] |-> walk_wdata == ctl)
    else $error("status does not mirror control");

  c_reg_write: cover property (reg_acc && reg_acc_wr);
  c_reg_read: cover property (reg_acc && !reg_acc_wr);
  c_bit_out: cover property (tb_bits_wr);
  c_img_done: cover property (img_done && in_len != 7'h00);

endmodule

// file: hw/pim_pkg.sv
// process image mapper: shared constants, kinds, states and state record
// assumes one 50 MHz clock domain shared by the plc side and the terminal chain
package pim_pkg;

  // ------------------------------------------------------------
  // image geometry
  // ------------------------------------------------------------
  localparam int          PIM_AW        = 6;
  localparam int          PIM_BYTES     = 64;
  localparam int          PIM_SLOT_W    = 5;
  localparam logic [4:0]  PIM_LAST_SLOT = 5'h1f;
  localparam logic [2:0]  PIM_ANA_LAST  = 3'h7;
  localparam logic [2:0]  PIM_SER_LAST  = 3'h5;
  localparam logic [1:0]  PIM_K_CTL     = 2'h0;
  localparam logic [1:0]  PIM_K_EMPTY   = 2'h1;
  localparam logic [1:0]  PIM_K_DLO     = 2'h2;
  localparam logic [7:0]  PIM_DIG_STEP  = 8'h02;
  localparam logic [8:0]  PIM_BYTE_RND  = 9'h007;

  // ------------------------------------------------------------
  // control / status byte layout
  // ------------------------------------------------------------
  localparam int          PIM_MODE_BIT  = 7;
  localparam int          PIM_DIR_BIT   = 6;
  localparam int          PIM_ADDR_MSB  = 5;
  localparam logic [7:0]  PIM_RES12_MSK = 8'hf0;
  localparam logic [7:0]  PIM_ZERO_BYTE = 8'h00;

  // ------------------------------------------------------------
  // terminal kinds and walker states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PIM_K_NONE = 3'b000,
    PIM_K_DIN  = 3'b001,
    PIM_K_DOUT = 3'b010,
    PIM_K_AIN  = 3'b011,
    PIM_K_AOUT = 3'b100,
    PIM_K_SER  = 3'b101
  } pim_kind_e;

  typedef enum logic [2:0] {
    PIM_ST_BYTE_REQ  = 3'b000,
    PIM_ST_BYTE_XFER = 3'b001,
    PIM_ST_BIT_REQ   = 3'b010,
    PIM_ST_BIT_XFER  = 3'b011,
    PIM_ST_DONE      = 3'b100
  } pim_st_e;

  typedef struct packed {
    pim_st_e     st;
    logic [4:0]  slot;
    logic [2:0]  bidx;
    logic [5:0]  bptr;
    logic [5:0]  bit_base;
    logic [7:0]  ibit;
    logic [7:0]  obit;
    logic [7:0]  iacc;
    logic [7:0]  wdata;
    logic        bwr;
    logic [1:0]  bout;
    logic        bitwr;
    logic        acc;
    logic        accwr;
    logic [5:0]  accaddr;
    logic        done;
    logic [6:0]  in_len;
    logic [6:0]  out_len;
  } pim_state_s;

  typedef struct packed {
    logic [PIM_BYTES-1:0][7:0] mem;
    logic [7:0]                rdata;
  } pim_ram_s;

endpackage

// file: hw/pim_ram.sv
// process image mapper: 64-byte image memory, registered read data
// assumes write and read share mclk; the clock enable freezes both ports
`timescale 1ns/1ps
module pim_ram
  import pim_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  nrst,
  input  wire logic  ce,
  pim_ram_if.mem     port
);

  pim_ram_s r_reg;
  pim_ram_s r_next;

  // ------------------------------------------------------------
  // write and registered read
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.rdata = r_reg.mem[port.raddr];
    if (port.we) begin
      r_next.mem[port.waddr] = port.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign port.rdata = r_reg.rdata;

endmodule

// file: hw/pim_ram_if.sv
// process image mapper: carrier between the mapper and one image memory
// assumes the owner drives one write port and one read address per cycle
`timescale 1ns/1ps
interface pim_ram_if;
  logic       we;
  logic [5:0] waddr;
  logic [7:0] wdata;
  logic [5:0] raddr;
  logic [7:0] rdata;
  modport user (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: verif/pim_chain_model.sv
// terminal chain model: answers kind, data and bits for the slot shown
// assumes the mapper walks slots and pulses byte and bit writes on mclk
`timescale 1ns/1ps
module pim_chain_model
  import pim_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       ser_on,
  input  wire logic [4:0] tb_slot,
  input  wire logic [2:0] tb_byte_sel,
  output logic      [2:0] tb_kind,
  output logic      [1:0] tb_ctl_en,
  output logic            tb_res12,
  output logic      [7:0] tb_rd_data,
  output logic      [1:0] tb_bits_in,
  input  wire logic [7:0] tb_wr_data,
  input  wire logic       tb_byte_wr,
  input  wire logic [1:0] tb_bits_out,
  input  wire logic       tb_bits_wr
);
  logic [7:0] byte_log [$];
  logic [1:0] bit_log  [$];

  // ------------------------------------------------------------
  // rail layout and answers
  // ------------------------------------------------------------
  always_comb begin
    case (tb_slot)
      5'h00:   tb_kind = PIM_K_DIN;
      5'h01:   tb_kind = PIM_K_AIN;
      5'h03:   tb_kind = PIM_K_DOUT;
      5'h04:   tb_kind = ser_on ? PIM_K_SER : PIM_K_NONE;
      5'h05:   tb_kind = PIM_K_DIN;
      5'h06:   tb_kind = PIM_K_AOUT;
      default: tb_kind = PIM_K_NONE;
    endcase
    case (tb_slot)
      5'h00:   tb_bits_in = 2'h1;
      5'h05:   tb_bits_in = 2'h2;
      default: tb_bits_in = 2'h3;
    endcase
  end
  // ctl byte on slot 1 channel 0
  assign tb_ctl_en  = (tb_slot == 5'h01) ? 2'h1 : 2'h0;
  assign tb_res12   = (tb_slot == 5'h01);
  // data pattern per slot and byte
  assign tb_rd_data = {tb_slot[3:0], 1'b1, tb_byte_sel};

  // ------------------------------------------------------------
  // capture of output traffic
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    if (tb_byte_wr === 1'b1) byte_log.push_back(tb_wr_data);
    if (tb_bits_wr === 1'b1) bit_log.push_back(tb_bits_out);
  end
endmodule

// file: verif/test_process_image_mapper.sv
// testbench: rail walk, image layout, control byte modes
// assumes pim_mapper top and the chain model beside it
`timescale 1ns/1ps
module test_process_image_mapper;
  import pim_pkg::*;
  logic       mclk, nrst, ce, plc_wr, ser_on;
  logic [5:0] plc_addr, reg_acc_addr;
  logic [7:0] plc_wdata, plc_rdata, tb_rd_data, tb_wr_data;
  logic [4:0] tb_slot;
  logic [2:0] tb_kind, tb_byte_sel;
  logic [1:0] tb_ctl_en, tb_bits_in, tb_bits_out;
  logic       tb_res12, tb_byte_wr, tb_bits_wr, reg_acc, reg_acc_wr, img_done;
  logic [6:0] in_len, out_len;
  int         failures, check_count, acc_cnt;

  pim_mapper dut_u (.mclk(mclk), .nrst(nrst), .ce(ce), .plc_addr(plc_addr),
    .plc_wr(plc_wr), .plc_wdata(plc_wdata), .plc_rdata(plc_rdata), .tb_slot(tb_slot),
    .tb_kind(tb_kind), .tb_ctl_en(tb_ctl_en), .tb_res12(tb_res12),
    .tb_byte_sel(tb_byte_sel), .tb_rd_data(tb_rd_data), .tb_wr_data(tb_wr_data),
    .tb_byte_wr(tb_byte_wr), .tb_bits_in(tb_bits_in), .tb_bits_out(tb_bits_out),
    .tb_bits_wr(tb_bits_wr), .reg_acc(reg_acc), .reg_acc_wr(reg_acc_wr),
    .reg_acc_addr(reg_acc_addr), .img_done(img_done), .in_len(in_len), .out_len(out_len));
  pim_chain_model chain_u (.mclk(mclk), .ser_on(ser_on), .tb_slot(tb_slot),
    .tb_byte_sel(tb_byte_sel), .tb_kind(tb_kind), .tb_ctl_en(tb_ctl_en),
    .tb_res12(tb_res12), .tb_rd_data(tb_rd_data), .tb_bits_in(tb_bits_in),
    .tb_wr_data(tb_wr_data), .tb_byte_wr(tb_byte_wr), .tb_bits_out(tb_bits_out),
    .tb_bits_wr(tb_bits_wr));

  // ------------------------------------------------------------
  // clock and helpers
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (reg_acc === 1'b1) acc_cnt++;

  task automatic finish_test();
    $display("failures=%0d check_count=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    @(negedge mclk);
    while (img_done !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 1000) begin
      $display("ERROR img_done expected 1 seen 0");
      failures++;
      finish_test();
    end
  endtask
  // one clean walk with fresh logs
  task automatic settle();
    wait_done();
    chain_u.byte_log.delete();
    chain_u.bit_log.delete();
    acc_cnt = 0;
    wait_done();
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(negedge mclk);
    plc_addr  = a;
    plc_wr    = 1'b1;
    plc_wdata = d;
    @(negedge mclk);
    plc_wr = 1'b0;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] exp);
    @(negedge mclk);
    plc_addr = a;
    @(negedge mclk);
    chk8($sformatf("in_image[%0d]", a), exp, plc_rdata);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_layout();
    logic [5:0] a [15] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 13, 14, 16, 17, 21, 22};
    logic [7:0] e [15] = '{8'h18, 8'h00, 8'h10, 8'h1b, 8'h00, 8'h00, 8'h10, 8'h1f,
                           8'h48, 8'h4d, 8'h00, 8'h6a, 8'h6b, 8'h6f, 8'h09};
    wr(6'h10, 8'h3c);
    wr(6'h11, 8'ha7);
    wr(6'h16, 8'hfe);
    wr(6'h00, 8'h45);
    settle();
    chk8("byte_log_size", 8'h16, 8'(chain_u.byte_log.size()));
    chk8("in_len", 8'h17, {1'b0, in_len});
    chk8("out_len", 8'h17, {1'b0, out_len});
    chk8("out_lo", 8'h3c, chain_u.byte_log[16]);
    chk8("out_hi", 8'ha7, chain_u.byte_log[17]);
    chk8("bits_out", 8'h02, {6'h0, chain_u.bit_log[0]});
    for (int i = 0; i < 15; i++) rd(a[i], e[i]);
  endtask

  task automatic t_ctl();
    logic [7:0] v [4] = '{8'h45, 8'hc5, 8'h8a, 8'hff};
    wr(6'h02, 8'h99);
    for (int i = 0; i < 4; i++) begin
      wr(6'h00, v[i]);
      settle();
      rd(6'h00, v[i][7] ? v[i] : 8'h18);
      chk8("acc_cnt", {7'h0, v[i][7]}, acc_cnt[7:0]);
      chk8("ctl_out", v[i], chain_u.byte_log[0]);
      chk8("word_out", 8'h99, chain_u.byte_log[2]);
      if (v[i][7]) begin
        chk8("acc_wr", {7'h0, v[i][6]}, {7'h0, reg_acc_wr});
        chk8("acc_addr", {2'h0, v[i][5:0]}, {2'h0, reg_acc_addr});
      end
    end
  endtask

  task automatic t_noser();
    logic [4:0] s;
    @(negedge mclk);
    ser_on = 1'b0;
    settle();
    chk8("byte_log_size", 8'h10, 8'(chain_u.byte_log.size()));
    chk8("in_len", 8'h11, {1'b0, in_len});
    chk8("out_len", 8'h11, {1'b0, out_len});
    rd(6'h0a, 8'h6a);
    rd(6'h10, 8'h09);
    @(negedge mclk);
    ce = 1'b0;
    s  = tb_slot;
    repeat (5) @(negedge mclk);
    chk8("slot_frozen", {3'h0, s}, {3'h0, tb_slot});
    ce = 1'b1;
  endtask

  initial begin
    nrst = 1'b0; ce = 1'b1; plc_wr = 1'b0; ser_on = 1'b1;
    plc_addr = 6'h00; plc_wdata = 8'h00;
    failures = 0; check_count = 0; acc_cnt = 0;
    repeat (2) @(negedge mclk);
    chk8("in_len_rst", 8'h00, {1'b0, in_len});
    chk8("slot_rst", 8'h00, {3'h0, tb_slot});
    nrst = 1'b1;
    t_layout();
    t_ctl();
    t_noser();
    finish_test();
  end
endmodule
